// *** pkg/xfer_queue_regs.svh ***
// Register map, field positions, reset values and sizes of the transfer queue
`ifndef XFER_QUEUE_REGS_SVH
`define XFER_QUEUE_REGS_SVH

// Byte offsets of the APB registers
`define OFS_CTRL        8'h00
`define OFS_CMD         8'h04
`define OFS_BLOCKS      8'h08
`define OFS_CAPACITY    8'h0c
`define OFS_FILL        8'h10
`define OFS_LOST        8'h14
`define OFS_STATE       8'h18
`define OFS_IRQ_STAT    8'h1c
`define OFS_IRQ_MASK    8'h20
`define OFS_ORDERING    8'h24
`define OFS_SENT        8'h28

// Control register fields
`define CTRL_METHOD_LSB 0
`define CTRL_STYLE_BIT  2
// Command register fields (write one to act)
`define CMD_GO_BIT      0
`define CMD_HALT_BIT    1
`define CMD_CLOSE_BIT   2
// Interrupt status and mask fields
`define IRQ_SENT_BIT    0
`define IRQ_LOST_BIT    1
`define IRQ_BURST_BIT   2
`define IRQ_WIDTH       3

// Queue sizes
`define QUEUE_DEPTH     8
`define PTR_WIDTH       3
`define LVL_WIDTH       4
`define TAG_WIDTH       16
`define PKT_WIDTH       12
`define CNT_WIDTH       16
`define TALLY_WIDTH     32

// Reset values
`define CTRL_RESET      3'h0
`define BLOCKS_RESET    16'h0001
`define ORDERING_FIFO   32'h0000_0000

`endif

// *** pkg/xfer_queue_pkg.sv ***
// Types shared by the transfer queue design
package xfer_queue_pkg;
`include "xfer_queue_regs.svh"

  // How transfers are started
  typedef enum logic [1:0] {
    METHOD_BASIC     = 2'h0,
    METHOD_AUTOMATIC = 2'h1,
    METHOD_USER      = 2'h2
  } xfer_control_method_type;

  // Run style used under user control
  typedef enum logic {
    STYLE_CONTINUOUS    = 1'b0,
    STYLE_COUNTED_BURST = 1'b1
  } xfer_run_style_type;

  // One queued block: handle, packets ready so far, block complete
  typedef struct packed {
    logic [`TAG_WIDTH-1:0] tag;
    logic [`PKT_WIDTH-1:0] avail;
    logic                  done;
  } queue_entry_type;

  // One packet offered on the stream channel
  typedef struct packed {
    logic [`TAG_WIDTH-1:0] tag;
    logic [`PKT_WIDTH-1:0] index;
    logic                  last;
  } pkt_info_type;

endpackage : xfer_queue_pkg

// *** logic/sat_counter.sv ***
// Saturating event counter with synchronous clear
module sat_counter
  import xfer_queue_pkg::*;
#(
  parameter int WIDTH = 32
)(
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic             clr,
  input  wire logic             inc,
  output logic [WIDTH-1:0]      count
);

  // Count up, hold at all ones instead of wrapping
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      count <= '0;
    else if (clr)
      count <= '0;
    else if (inc && (count != {WIDTH{1'b1}}))
      count <= count + 1'b1;            // [RULE18]
  end

endmodule : sat_counter

// *** logic/image_block_transfer_queue.sv ***
// Block transfer queue, transmit scheduler and APB register file
// Behaviour
// [RULE1] Each processed frame is queued as one block
// [RULE2] Basic/automatic send starts after one packet ready
// [RULE3] Blocks go back to back when link keeps up
// [RULE4] Waiting blocks accumulate in the queue
// [RULE5] Queue capacity readable, read only
// [RULE6] Current fill level readable, tracks every change
// [RULE7] Oldest queued block is always sent next
// [RULE8] Full queue overwrites oldest unsent, never current
// [RULE9] Each overwrite increments the lost block tally
// [RULE10] Next oldest block starts when current completes
// [RULE11] User continuous streams, gated by go/halt only
// [RULE12] Counted burst sends exactly blocks_to_send, stops
// [RULE13] Acquisition start/stop leaves queue state alone
// [RULE14] Channel close empties queue, cancels transmission
// [RULE15] Halt lets the block in progress finish
// [RULE16] Go/halt accepted only under user control
// [RULE17] Block count used only in counted burst
// [RULE18] Lost tally saturates instead of wrapping
module image_block_transfer_queue
  import xfer_queue_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  arst_n,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // Processing side: block start, packet accumulated, block end
  input  wire logic                  blk_start,
  input  wire logic [`TAG_WIDTH-1:0] blk_tag,
  input  wire logic                  blk_pkt,
  input  wire logic                  blk_end,
  // Stream channel
  output logic                       pkt_valid,
  output pkt_info_type               pkt_info,
  input  wire logic                  pkt_ready,
  // Interrupt
  output logic                       irq
);

  // Queue storage and pointers (untransmitted blocks only)
  queue_entry_type              mem [`QUEUE_DEPTH];
  logic [`PTR_WIDTH-1:0]        rd_ptr_reg;   // Oldest entry
  logic [`PTR_WIDTH-1:0]        wr_ptr_reg;   // Next free slot
  logic [`LVL_WIDTH-1:0]        count_reg;    // Entries held
  logic                         acq_open_reg; // Newest block still growing
  // Block in transmission
  logic                         cur_busy_reg;
  logic [`PKT_WIDTH-1:0]        cur_avail_reg;
  logic                         cur_done_reg;
  // Software state
  xfer_control_method_type      method_reg;
  xfer_run_style_type           style_reg;
  logic [`CNT_WIDTH-1:0]        blocks_reg;    // blocks_to_send
  logic [`CNT_WIDTH-1:0]        remain_reg;    // Blocks left in burst
  logic                         run_reg;       // User go/halt state
  logic [`IRQ_WIDTH-1:0]        irq_stat_reg;
  logic [`IRQ_WIDTH-1:0]        irq_mask_reg;
  logic [`TALLY_WIDTH-1:0]      lost_count;    // lost_block_tally
  logic [`TALLY_WIDTH-1:0]      sent_count;

  // APB access strobes
  logic                         acc;           // Access accepted this edge
  logic                         wr_acc;
  logic                         go_cmd;        // stream_go_cmd
  logic                         halt_cmd;      // stream_halt_cmd
  logic                         close_cmd;     // Stream channel closed
  // Queue control
  logic                         full;
  logic                         empty;
  logic                         send_ok;       // Scheduler allowed to start
  logic                         fire;          // Packet taken by link
  logic                         fin;           // Last packet of block taken
  logic                         load;          // Head moves to transmitter
  logic                         push;
  logic                         overwrite;     // Full queue drop
  logic                         newest_in_cur; // Growing block is current
  logic [`PTR_WIDTH-1:0]        tail_ptr;      // Newest queued entry
  logic                         tail_grow;
  logic                         tail_end;
  logic                         head_is_tail;
  queue_entry_type              head_eff;      // Head with same-cycle update
  logic                         burst_last;    // Load that ends a burst
  logic [`PKT_WIDTH-1:0]        next_idx;

  assign acc       = psel && penable && pready;
  assign wr_acc    = acc && pwrite;
  assign go_cmd    = wr_acc && (paddr == `OFS_CMD) && pwdata[`CMD_GO_BIT]
                     && (method_reg == METHOD_USER);        // [RULE16]
  assign halt_cmd  = wr_acc && (paddr == `OFS_CMD) && pwdata[`CMD_HALT_BIT]
                     && (method_reg == METHOD_USER);        // [RULE16]
  assign close_cmd = wr_acc && (paddr == `OFS_CMD)
                     && pwdata[`CMD_CLOSE_BIT];

  assign full  = (count_reg == `LVL_WIDTH'(`QUEUE_DEPTH));
  assign empty = (count_reg == '0);
  // Automatic methods always stream; user method only while running
  assign send_ok = (method_reg != METHOD_USER) || run_reg;  // [RULE11]
  assign fire    = pkt_valid && pkt_ready;
  assign fin     = fire && pkt_info.last;
  // Next block starts in the very cycle the current one ends
  assign load    = (!cur_busy_reg || fin) && !empty && send_ok
                   && !close_cmd;                   // [RULE3] [RULE10]
  assign push      = blk_start && !close_cmd;               // [RULE1]
  assign overwrite = push && full && !load;                 // [RULE8]
  assign newest_in_cur = empty && cur_busy_reg && acq_open_reg;
  assign tail_ptr      = wr_ptr_reg - 1'b1;
  assign tail_grow     = blk_pkt && acq_open_reg && !empty;
  assign tail_end      = blk_end && acq_open_reg && !empty;
  assign head_is_tail  = (count_reg == `LVL_WIDTH'(1));
  assign burst_last    = (style_reg == STYLE_COUNTED_BURST)
                         && (remain_reg == `CNT_WIDTH'(1));
  assign next_idx      = pkt_info.index + 1'b1;

  // Head entry as seen by a load, including growth in this cycle
  always_comb
  begin
    head_eff = mem[rd_ptr_reg];
    if (head_is_tail && tail_grow)
      head_eff.avail = head_eff.avail + 1'b1;
    if (head_is_tail && tail_end)
      head_eff.done = 1'b1;
  end

  // Queue storage: new entries, growth of the newest, overwrite
  always_ff @(posedge core_clk)
  begin
    if (push)
      mem[wr_ptr_reg] <= '{tag: blk_tag, avail: '0, done: 1'b0};
    else if (tail_grow)
      mem[tail_ptr].avail <= mem[tail_ptr].avail + 1'b1;    // [RULE4]
    else if (tail_end)
      mem[tail_ptr].done <= 1'b1;
  end

  // Queue pointers and fill level, oldest always leaves first
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_ptr_reg <= '0;
      wr_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else if (close_cmd)
    begin
      rd_ptr_reg <= '0;                                     // [RULE14]
      wr_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (load || overwrite)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;                    // [RULE7]
      if (push && !load && !full)
        count_reg <= count_reg + 1'b1;                      // [RULE6]
      else if (load && !push)
        count_reg <= count_reg - 1'b1;                      // [RULE6]
    end
  end

  // Tracks whether the newest block is still receiving packets
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      acq_open_reg <= 1'b0;
    else if (close_cmd)
      acq_open_reg <= 1'b0;
    else if (push)
      acq_open_reg <= 1'b1;                                 // [RULE13]
    else if (blk_end)
      acq_open_reg <= 1'b0;
  end

  // Transmitter: current block and packet offered to the link
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cur_busy_reg  <= 1'b0;
      cur_avail_reg <= '0;
      cur_done_reg  <= 1'b0;
      pkt_valid     <= 1'b0;
      pkt_info      <= '0;
    end
    else if (close_cmd)
    begin
      cur_busy_reg <= 1'b0;                                 // [RULE14]
      pkt_valid    <= 1'b0;
    end
    else if (load)
    begin
      // First packet goes out as soon as one is ready
      cur_busy_reg   <= 1'b1;
      cur_avail_reg  <= head_eff.avail;
      cur_done_reg   <= head_eff.done;
      pkt_info.tag   <= head_eff.tag;
      pkt_info.index <= '0;
      pkt_info.last  <= head_eff.done
                        && (head_eff.avail == `PKT_WIDTH'(1));
      pkt_valid      <= (head_eff.avail != '0);             // [RULE2]
    end
    else if (fin)
    begin
      cur_busy_reg <= 1'b0;
      pkt_valid    <= 1'b0;
    end
    else if (cur_busy_reg)
    begin
      if (newest_in_cur && blk_pkt)
        cur_avail_reg <= cur_avail_reg + 1'b1;
      if (newest_in_cur && blk_end)
        cur_done_reg <= 1'b1;
      if (fire)
      begin
        pkt_info.index <= next_idx;
        pkt_valid      <= 1'b0;
      end
      else if (!pkt_valid && (pkt_info.index < cur_avail_reg))
      begin
        pkt_valid     <= 1'b1;                              // [RULE2]
        pkt_info.last <= cur_done_reg
                         && (next_idx == cur_avail_reg);
      end
    end
  end

  // Go/halt state and remaining count of a counted burst
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      run_reg    <= 1'b0;
      remain_reg <= '0;
    end
    else if (close_cmd || halt_cmd)
      run_reg <= 1'b0;                                      // [RULE15]
    else if (go_cmd)
    begin
      if (style_reg == STYLE_COUNTED_BURST)
      begin
        remain_reg <= blocks_reg;                           // [RULE17]
        run_reg    <= (blocks_reg != '0);                   // [RULE12]
      end
      else
        run_reg <= 1'b1;                                    // [RULE11]
    end
    else if (load && (method_reg == METHOD_USER)
             && (style_reg == STYLE_COUNTED_BURST))
    begin
      remain_reg <= remain_reg - 1'b1;                      // [RULE12]
      if (burst_last)
        run_reg <= 1'b0;                                    // [RULE12]
    end
  end

  // Lost and sent block tallies
  sat_counter #(.WIDTH(`TALLY_WIDTH)) u_lost_tally (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .clr      (1'b0),
    .inc      (overwrite),                                  // [RULE9]
    .count    (lost_count)
  );

  sat_counter #(.WIDTH(`TALLY_WIDTH)) u_sent_tally (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .clr      (close_cmd),
    .inc      (fin),
    .count    (sent_count)
  );

  // Software configuration registers
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      method_reg   <= METHOD_BASIC;
      style_reg    <= STYLE_CONTINUOUS;
      blocks_reg   <= `BLOCKS_RESET;
      irq_mask_reg <= '0;
    end
    else if (wr_acc)
    begin
      case (paddr)
        `OFS_CTRL:
        begin
          if (pwdata[`CTRL_METHOD_LSB+1:`CTRL_METHOD_LSB] != 2'h3)
            method_reg <= xfer_control_method_type'(
                            pwdata[`CTRL_METHOD_LSB+1:`CTRL_METHOD_LSB]);
          style_reg <= xfer_run_style_type'(pwdata[`CTRL_STYLE_BIT]);
        end
        `OFS_BLOCKS:   blocks_reg   <= pwdata[`CNT_WIDTH-1:0];
        `OFS_IRQ_MASK: irq_mask_reg <= pwdata[`IRQ_WIDTH-1:0];
        default:       ;
      endcase
    end
  end

  // Sticky events, a new event wins over a write-one clear
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      irq_stat_reg <= '0;
    else
      irq_stat_reg <= (irq_stat_reg
                       & ~((wr_acc && (paddr == `OFS_IRQ_STAT))
                           ? pwdata[`IRQ_WIDTH-1:0] : `IRQ_WIDTH'(0)))
                      | {load && burst_last && (method_reg == METHOD_USER),
                         overwrite, fin};
  end

  // Level interrupt from unmasked sticky bits
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_reg & irq_mask_reg);
  end

  // APB answer: one wait state, read data and error registered
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && penable && !pready;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (psel && penable && !pready)
      begin
        case (paddr)
          `OFS_CTRL:     prdata <= {29'h0, style_reg, method_reg};
          `OFS_CMD:      prdata <= '0;
          `OFS_BLOCKS:   prdata <= {16'h0, blocks_reg};
          `OFS_CAPACITY: prdata <= 32'(`QUEUE_DEPTH);      // [RULE5]
          `OFS_FILL:     prdata <= {28'h0, count_reg};     // [RULE6]
          `OFS_LOST:     prdata <= lost_count;              // [RULE9]
          `OFS_STATE:    prdata <= {30'h0, cur_busy_reg, run_reg};
          `OFS_IRQ_STAT: prdata <= {29'h0, irq_stat_reg};
          `OFS_IRQ_MASK: prdata <= {29'h0, irq_mask_reg};
          `OFS_ORDERING: prdata <= `ORDERING_FIFO;
          `OFS_SENT:     prdata <= sent_count;
          default:       pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Checks
  property p_lost_count;
    @(posedge core_clk) disable iff (!arst_n)
    (overwrite && (lost_count != 32'hffff_ffff))
      |=> (lost_count == $past(lost_count) + 32'h1);
  endproperty
  a_lost_count: assert property (p_lost_count) // [RULE9]
    else $error("lost tally did not count an overwrite");

  property p_lost_sat;
    @(posedge core_clk) disable iff (!arst_n)
    (lost_count == 32'hffff_ffff) |=> (lost_count == 32'hffff_ffff);
  endproperty
  a_lost_sat: assert property (p_lost_sat) // [RULE18]
    else $error("lost tally wrapped");

  property p_level_bound;
    @(posedge core_clk) disable iff (!arst_n)
    count_reg <= `LVL_WIDTH'(`QUEUE_DEPTH);
  endproperty
  a_level_bound: assert property (p_level_bound) // [RULE4]
    else $error("fill level above capacity");

  property p_close;
    @(posedge core_clk) disable iff (!arst_n)
    close_cmd |=> (count_reg == '0) && !cur_busy_reg && !pkt_valid;
  endproperty
  a_close: assert property (p_close) // [RULE14]
    else $error("close left queue or transmission");

  property p_halt_finish;
    @(posedge core_clk) disable iff (!arst_n)
    (halt_cmd && cur_busy_reg && !fin && !close_cmd) |=> cur_busy_reg;
  endproperty
  a_halt_finish: assert property (p_halt_finish) // [RULE15]
    else $error("halt cut the current block short");

  property p_go_user_only;
    @(posedge core_clk) disable iff (!arst_n)
    (method_reg != METHOD_USER) && !run_reg |=> !run_reg;
  endproperty
  a_go_user_only: assert property (p_go_user_only) // [RULE16]
    else $error("run started outside user control");

  property p_next_block;
    @(posedge core_clk) disable iff (!arst_n)
    (fin && !empty && send_ok && !close_cmd)
      |=> cur_busy_reg && (count_reg == $past(count_reg) - 4'h1
                           + {3'h0, $past(push)});
  endproperty
  a_next_block: assert property (p_next_block) // [RULE10]
    else $error("next block not started at once");

  property p_first_pkt;
    @(posedge core_clk) disable iff (!arst_n)
    (cur_busy_reg && !pkt_valid && (pkt_info.index < cur_avail_reg)
     && !close_cmd && !fin) |=> pkt_valid;
  endproperty
  a_first_pkt: assert property (p_first_pkt) // [RULE2]
    else $error("ready packet not offered");

  property p_keep_current;
    @(posedge core_clk) disable iff (!arst_n)
    overwrite && cur_busy_reg && !fin |=> $stable(pkt_info.tag);
  endproperty
  a_keep_current: assert property (p_keep_current) // [RULE8]
    else $error("overwrite disturbed current block");

  property p_burst_stop;
    @(posedge core_clk) disable iff (!arst_n)
    (load && burst_last && (method_reg == METHOD_USER) && !go_cmd)
      |=> !run_reg ##1 !load [*2];
  endproperty
  a_burst_stop: assert property (p_burst_stop) // [RULE12]
    else $error("counted burst did not stop");

  c_overwrite: cover property (@(posedge core_clk) disable iff (!arst_n)
                               overwrite);
  c_back2back: cover property (@(posedge core_clk) disable iff (!arst_n)
                               fin && load);
  c_burst:     cover property (@(posedge core_clk) disable iff (!arst_n)
                               load && burst_last);

endmodule : image_block_transfer_queue

// *** verification/stream_host_model.sv ***
// Host end of the stream channel: takes packets and logs finished blocks
module stream_host_model
  import xfer_queue_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  input  wire logic         pkt_valid,
  input  wire pkt_info_type pkt_info,
  input  wire logic         stall,
  output logic              pkt_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] done_q[$];          // Tags of finished blocks, in order
  int          bad_idx = 0;        // Packets out of index sequence
  logic [11:0] exp_idx = 12'h000;  // Index expected next
  // Ready follows the stall request one cycle late, as a slow host does
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      pkt_ready <= 1'b0;
    else
      pkt_ready <= !stall;
  end
  // Log each accepted packet; a last packet closes the block
  always @(posedge core_clk)
  begin
    if (arst_n && pkt_valid === 1'b1 && pkt_ready === 1'b1)
    begin
      if (pkt_info.index !== exp_idx)
        bad_idx++;
      exp_idx = pkt_info.last ? 12'h000 : exp_idx + 12'h001;
      if (pkt_info.last)
        done_q.push_back(pkt_info.tag);
    end
  end
endmodule : stream_host_model

// *** verification/tb.sv ***
// Self-checking bench for the transfer queue over APB and stream
`include "xfer_queue_regs.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tb
  import xfer_queue_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         core_clk = 1'b0;
  logic         arst_n = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [7:0]   paddr = 8'h00;
  logic [31:0]  pwdata = 32'h0;
  logic [31:0]  prdata;
  logic [31:0]  rdv;             // Data of the last read
  logic         pready;
  logic         pslverr;
  logic         err;             // Error flag of the last transfer
  logic         irq;
  logic         pkt_valid;
  logic         pkt_ready;
  logic         stall = 1'b1;    // Host holds the link back
  logic         blk_start = 1'b0;
  logic         blk_pkt = 1'b0;
  logic         blk_end = 1'b0;
  logic [15:0]  blk_tag = 16'h0;
  pkt_info_type pkt_info;
  int           n_fail = 0;
  int           checked = 0;
  int           n;
  logic [15:0]  exp_q[$];        // Expected order of finished blocks
  // 200 MHz clock
  always #2.5 core_clk = ~core_clk;
  image_block_transfer_queue dut (
    .core_clk (core_clk), .arst_n (arst_n), .psel (psel),
    .penable (penable), .pwrite (pwrite), .paddr (paddr),
    .pwdata (pwdata), .pready (pready), .prdata (prdata),
    .pslverr (pslverr), .blk_start (blk_start), .blk_tag (blk_tag),
    .blk_pkt (blk_pkt), .blk_end (blk_end), .pkt_valid (pkt_valid),
    .pkt_info (pkt_info), .pkt_ready (pkt_ready), .irq (irq)
  );
  stream_host_model host (
    .core_clk (core_clk), .arst_n (arst_n), .pkt_valid (pkt_valid),
    .pkt_info (pkt_info), .stall (stall), .pkt_ready (pkt_ready)
  );
  // Verdict and end of run
  task automatic stop_test;
    if (n_fail == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  // One APB transfer; request held until pready is sampled high
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rdv = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
    if (n >= 50)
    begin
      n_fail++;
      stop_test();
    end
  endtask : bus
  // Read a register and compare it
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK($sformatf("reg %0h", a), e, rdv)
  endtask : rdc
  // Packet-ready pulses of the open block, then optionally its end
  task automatic pkts(input int np, input logic fin);
    blk_pkt <= 1'b1;
    repeat (np) @(posedge core_clk);
    blk_pkt <= 1'b0;
    blk_end <= fin;
    @(posedge core_clk);
    blk_end <= 1'b0;
  endtask : pkts
  // A new block with its packets
  task automatic blk(input logic [15:0] t, input int np, input logic fin);
    blk_start <= 1'b1;
    blk_tag   <= t;
    @(posedge core_clk);
    blk_start <= 1'b0;
    pkts(np, fin);
  endtask : blk
  // Bounded wait: k < 0 for an offered packet, else k finished blocks
  task automatic wait_for(input int k);
    n = 0;
    while ((k < 0 ? pkt_valid !== 1'b1 : host.done_q.size() < k)
           && n < 2000)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 2000)
    begin
      n_fail++;
      stop_test();
    end
  endtask : wait_for
  // Main sequence
  initial
  begin
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    rdc(`OFS_BLOCKS, 32'h1);
    bus(1'b1, `OFS_CAPACITY, 32'h3);
    rdc(`OFS_CAPACITY, 32'h8);
    rdc(`OFS_ORDERING, 32'h0);
    rdc(8'h30, 32'h0);
    `CHK("pslverr", 1'b1, err)
    // Basic mode, host stalled: fill, overflow, then drain
    blk(16'h1, 1, 1'b0);
    wait_for(-1);
    `CHK("tag", 16'h1, pkt_info.tag)
    `CHK("index", 12'h0, pkt_info.index)
    rdc(`OFS_FILL, 32'h0);
    pkts(1, 1'b1);
    exp_q.push_back(16'h1);
    for (int t = 2; t <= 9; t++)
      blk(16'(t), 2, 1'b1);
    rdc(`OFS_FILL, 32'h8);
    blk(16'ha, 2, 1'b1);
    for (int t = 3; t <= 10; t++)
      exp_q.push_back(16'(t));
    rdc(`OFS_FILL, 32'h8);
    rdc(`OFS_LOST, 32'h1);
    rdc(`OFS_IRQ_STAT, 32'h2);
    `CHK("irq", 1'b0, irq)
    bus(1'b1, `OFS_IRQ_MASK, 32'h2);
    @(posedge core_clk);
    `CHK("irq", 1'b1, irq)
    bus(1'b1, `OFS_IRQ_STAT, 32'h2);
    @(posedge core_clk);
    `CHK("irq", 1'b0, irq)
    stall <= 1'b0;
    wait_for(9);
    // User control, continuous: go and halt
    bus(1'b1, `OFS_CMD, 32'h1);
    rdc(`OFS_STATE, 32'h0);
    bus(1'b1, `OFS_CTRL, 32'h2);
    stall <= 1'b1;
    blk(16'h14, 2, 1'b1);
    blk(16'h15, 2, 1'b1);
    repeat (20) @(posedge core_clk);
    `CHK("valid", 1'b0, pkt_valid)
    rdc(`OFS_FILL, 32'h2);
    bus(1'b1, `OFS_CMD, 32'h1);
    wait_for(-1);
    bus(1'b1, `OFS_CMD, 32'h2);
    rdc(`OFS_STATE, 32'h2);
    stall <= 1'b0;
    wait_for(10);
    exp_q.push_back(16'h14);
    repeat (30) @(posedge core_clk);
    `CHK("blocks", 10, host.done_q.size())
    // Counted burst of two from a queue of two
    bus(1'b1, `OFS_BLOCKS, 32'h2);
    bus(1'b1, `OFS_CTRL, 32'h6);
    rdc(`OFS_CTRL, 32'h6);
    blk(16'h16, 2, 1'b1);
    rdc(`OFS_FILL, 32'h2);
    bus(1'b1, `OFS_CMD, 32'h1);
    wait_for(12);
    exp_q.push_back(16'h15);
    exp_q.push_back(16'h16);
    repeat (30) @(posedge core_clk);
    `CHK("blocks", 12, host.done_q.size())
    rdc(`OFS_IRQ_STAT, 32'h5);
    blk(16'h17, 2, 1'b1);
    rdc(`OFS_FILL, 32'h1);
    // Channel close empties the queue and the sent tally, a block in flight too
    stall <= 1'b1;
    blk(16'h18, 2, 1'b1);
    bus(1'b1, `OFS_CTRL, 32'h0);
    wait_for(-1);
    bus(1'b1, `OFS_CMD, 32'h4);
    `CHK("valid", 1'b0, pkt_valid)
    rdc(`OFS_STATE, 32'h0);
    rdc(`OFS_FILL, 32'h0);
    rdc(`OFS_SENT, 32'h0);
    `CHK("bad index", 0, host.bad_idx)
    foreach (exp_q[i])
      `CHK("order", exp_q[i], host.done_q[i])
    stop_test();
  end
endmodule : tb
